// ==== io_port_pin_config.sv ====
// Three 8-bit I/O ports with per-pin modes, timer toggles and clock output.
//
// How it works
// - Two per-pin bits select quasi, push-pull, input only or open drain.
// - Per-port select bit picks Schmitt inputs when one, TTL when zero.
// - Every configurable pin starts in quasi-bidirectional mode after any reset.
// - Boot byte bit 5 chooses whether all port latches reset low or high.
// - Dedicated input pin never drives and uses a Schmitt input from the first enabled clock after reset.
// - Boot byte bit 6 zero makes the dedicated pin the reset input.
// - Enabled timer toggles its pin on every overflow of that timer.
// - Clock output enable drives a quarter-rate CPU clock on its pin.
// - Clock output only without crystal source, and keeps running in idle.
// - Quasi pin rising from 0 to 1 gets strong pull-up for two clocks.
// - Quasi pin drives low strongly for 0 and is held high otherwise.
// - Three pull-up stages; strong one only for the rising edge boost.
`timescale 1ns/1ps
`include "io_port_consts.svh"

module io_port_pin_config (
   input  wire logic        mclk_in,
   input  wire logic        resetn_in,
   input  wire logic        ce_in,
   input  wire logic [7:0]  boot_option_byte_one_in,
   input  wire logic        crystal_source_in,
   input  wire logic        latch_wr_in,
   input  wire logic [23:0] latch_wdata_in,
   input  wire logic        mode_wr_in,
   input  wire logic [23:0] pin_mode_bit_a_in,
   input  wire logic [23:0] pin_mode_bit_b_in,
   input  wire logic        port_two_mode_one_wr_in,
   input  wire logic [7:0]  port_two_mode_one_wdata_in,
   input  wire logic        timer_a_overflow_in,
   input  wire logic        timer_b_overflow_in,
   input  wire logic [23:0] pin_in,
   output logic      [23:0] pin_out,
   output logic      [23:0] pin_oe_out,
   output logic      [23:0] strong_pullup_out,
   output logic      [23:0] weak_pullup_out,
   output logic      [23:0] very_weak_pullup_out,
   output logic      [23:0] schmitt_enable_out,
   output logic      [23:0] pin_read_out,
   output logic      [7:0]  port_two_mode_one_out,
   output logic             reset_pin_request_out
);
   import io_port_pkg::*;

   logic [7:0]  boot_reg;
   logic        boot_valid_reg;
   logic [23:0] latch_reg;
   logic [23:0] mode_a_reg;
   logic [23:0] mode_b_reg;
   logic        toggle_a_reg;
   logic        toggle_b_reg;
   logic [1:0]  clk_div_reg;
   logic        clk_out_reg;
   logic [23:0] eff_latch;
   pin_mode_t   eff_mode [`PIN_COUNT];
   logic [23:0] cell_read;
   logic        clock_out_active;
   logic [2:0]  settle_reg;
   logic        read_settled;

   // ----------------------------------------
   // Boot option capture and port latches
   // ----------------------------------------
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         boot_reg       <= 8'h00;
         boot_valid_reg <= 1'b0;
      end else if (ce_in && !boot_valid_reg) begin
         boot_reg       <= boot_option_byte_one_in;
         boot_valid_reg <= 1'b1;
      end
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         latch_reg <= 24'h000000;
      end else if (ce_in) begin
         if (!boot_valid_reg) begin
            latch_reg <= {24{boot_option_byte_one_in[`PORT_RESET_LEVEL_BIT]}};
         end else if (latch_wr_in) begin
            latch_reg <= latch_wdata_in;
         end
      end
   end

   // ----------------------------------------
   // Mode registers
   // ----------------------------------------
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mode_a_reg <= `MODE_BITS_RESET;
         mode_b_reg <= `MODE_BITS_RESET;
      end else if (ce_in && mode_wr_in) begin
         mode_a_reg <= pin_mode_bit_a_in;
         mode_b_reg <= pin_mode_bit_b_in;
      end
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         port_two_mode_one_out <= 8'h00;
      end else if (ce_in && port_two_mode_one_wr_in) begin
         port_two_mode_one_out <= port_two_mode_one_wdata_in;
      end
   end

   // ----------------------------------------
   // Timer toggles and clock output
   // ----------------------------------------
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         toggle_a_reg <= 1'b0;
         toggle_b_reg <= 1'b0;
      end else if (ce_in) begin
         if (timer_a_overflow_in) begin
            toggle_a_reg <= !toggle_a_reg;
         end
         if (timer_b_overflow_in) begin
            toggle_b_reg <= !toggle_b_reg;
         end
      end
   end

   // No idle input exists here, so the divider runs whenever clock output is enabled and no crystal source is selected.
   assign clock_out_active = port_two_mode_one_out[`CLOCK_OUT_EN_BIT] && !crystal_source_in;

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         clk_div_reg <= 2'h0;
         clk_out_reg <= 1'b0;
      end else if (ce_in) begin
         if (clock_out_active) begin
            clk_div_reg <= clk_div_reg + 2'h1;
            if (clk_div_reg == 2'(`CLOCK_OUT_DIVIDE / 2 - 1)) begin
               clk_div_reg <= 2'h0;
               clk_out_reg <= !clk_out_reg;
            end
         end else begin
            clk_div_reg <= 2'h0;
            clk_out_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Effective latch and mode per pin
   // ----------------------------------------
   always_comb begin
      eff_latch = latch_reg;
      for (int i = 0; i < `PIN_COUNT; i++) begin
         eff_mode[i] = pin_mode_t'({mode_a_reg[i], mode_b_reg[i]});
      end
      if (port_two_mode_one_out[`TIMER_A_TOGGLE_EN_BIT]) begin
         eff_latch[`TIMER_A_PIN] = toggle_a_reg;
         eff_mode[`TIMER_A_PIN]  = MODE_PUSH_PULL;
      end
      if (port_two_mode_one_out[`TIMER_B_TOGGLE_EN_BIT]) begin
         eff_latch[`TIMER_B_PIN] = toggle_b_reg;
         eff_mode[`TIMER_B_PIN]  = MODE_PUSH_PULL;
      end
      if (clock_out_active) begin
         eff_latch[`CLOCK_OUTPUT_PIN] = clk_out_reg;
         eff_mode[`CLOCK_OUTPUT_PIN]  = MODE_PUSH_PULL;
      end
      eff_mode[`DEDICATED_INPUT_PIN] = MODE_INPUT;
   end

   // ----------------------------------------
   // Pin cells
   // ----------------------------------------
   for (genvar g = 0; g < `PIN_COUNT; g++) begin : g_pin
      io_pin_cell u_cell (
         .mclk_in              (mclk_in),
         .resetn_in            (resetn_in),
         .ce_in                (ce_in),
         .latch_in             (eff_latch[g]),
         .mode_in              (eff_mode[g]),
         .pin_in               (pin_in[g]),
         .pad_out              (pin_out[g]),
         .pad_oe_out           (pin_oe_out[g]),
         .strong_pullup_out    (strong_pullup_out[g]),
         .weak_pullup_out      (weak_pullup_out[g]),
         .very_weak_pullup_out (very_weak_pullup_out[g]),
         .read_out             (cell_read[g])
      );
   end

   // ----------------------------------------
   // Input threshold, read value and reset pin
   // ----------------------------------------
   // The synchronised pin value starts at zero, so a reset request is held off until the
   // synchroniser has filled; otherwise every reset would be followed by a false request.
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         settle_reg <= 3'h0;
      end else if (ce_in && settle_reg != 3'(`READ_SETTLE_CYCLES)) begin
         settle_reg <= settle_reg + 3'h1;
      end
   end

   assign read_settled = (settle_reg == 3'(`READ_SETTLE_CYCLES));

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         schmitt_enable_out    <= 24'h000000;
         pin_read_out          <= 24'h000000;
         reset_pin_request_out <= 1'b0;
      end else if (ce_in) begin
         for (int p = 0; p < 3; p++) begin
            schmitt_enable_out[p*8 +: 8] <= {8{port_two_mode_one_out[`THRESHOLD_SEL_LSB + p]}};
         end
         schmitt_enable_out[`DEDICATED_INPUT_PIN] <= 1'b1;
         pin_read_out <= cell_read;
         if (boot_valid_reg && !boot_reg[`RESET_PIN_DISABLE_BIT]) begin
            pin_read_out[`DEDICATED_INPUT_PIN] <= 1'b0;
            reset_pin_request_out              <= read_settled && !cell_read[`DEDICATED_INPUT_PIN];
         end else begin
            reset_pin_request_out <= 1'b0;
         end
      end
   end

endmodule

// ==== io_port_consts.svh ====
// Offsets, field positions, reset values and timing counts of the I/O port block.
`ifndef IO_PORT_CONSTS_SVH
`define IO_PORT_CONSTS_SVH

// ----------------------------------------
// Boot option byte fields
// ----------------------------------------
`define RESET_PIN_DISABLE_BIT    6
`define PORT_RESET_LEVEL_BIT     5

// ----------------------------------------
// Port-two mode-one register fields
// ----------------------------------------
`define THRESHOLD_SEL_LSB        0
`define TIMER_A_TOGGLE_EN_BIT    3
`define TIMER_B_TOGGLE_EN_BIT    4
`define CLOCK_OUT_EN_BIT         5

// ----------------------------------------
// Pin positions (port n bit y is index 8n+y)
// ----------------------------------------
`define PIN_COUNT                24
`define DEDICATED_INPUT_PIN      13
`define CLOCK_OUTPUT_PIN         16
`define TIMER_A_PIN              6
`define TIMER_B_PIN              7

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define MODE_BITS_RESET          24'h000000
`define STRONG_PULL_CYCLES       2
`define CLOCK_OUT_DIVIDE         4
`define READ_SETTLE_CYCLES       4

`endif

// ==== io_port_pkg.sv ====
// Types shared by the I/O port block.
package io_port_pkg;

   typedef enum logic [1:0] {
      MODE_QUASI     = 2'b00,
      MODE_PUSH_PULL = 2'b01,
      MODE_INPUT     = 2'b10,
      MODE_OPEN      = 2'b11
   } pin_mode_t;

endpackage

// ==== io_pin_cell.sv ====
// One port pin: output driver control, pull-up stages and synchronised input.
`timescale 1ns/1ps
`include "io_port_consts.svh"

module io_pin_cell (
   input  wire logic                   mclk_in,
   input  wire logic                   resetn_in,
   input  wire logic                   ce_in,
   input  wire logic                   latch_in,
   input  wire io_port_pkg::pin_mode_t mode_in,
   input  wire logic                   pin_in,
   output logic                        pad_out,
   output logic                        pad_oe_out,
   output logic                        strong_pullup_out,
   output logic                        weak_pullup_out,
   output logic                        very_weak_pullup_out,
   output logic                        read_out
);
   import io_port_pkg::*;

   logic       sync1_reg;
   logic       sync2_reg;
   logic       sync3_reg;
   logic       latch_prev_reg;
   logic [1:0] boost_cnt_reg;
   logic       boost;

   // ----------------------------------------
   // Input synchroniser
   // ----------------------------------------
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sync3_reg <= 1'b0;
         read_out  <= 1'b0;
      end else if (ce_in) begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         if (sync2_reg == sync3_reg) begin
            read_out <= sync3_reg;
         end
      end
   end

   // ----------------------------------------
   // Strong pull-up boost
   // ----------------------------------------
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         latch_prev_reg <= 1'b0;
         boost_cnt_reg  <= 2'h0;
      end else if (ce_in) begin
         latch_prev_reg <= latch_in;
         if (mode_in == MODE_QUASI && latch_in && !latch_prev_reg) begin
            boost_cnt_reg <= 2'(`STRONG_PULL_CYCLES);
         end else if (boost_cnt_reg != 2'h0) begin
            boost_cnt_reg <= boost_cnt_reg - 2'h1;
         end
      end
   end

   // A new 0-to-1 edge and the running boost both count toward the two clocks.
   assign boost = (mode_in == MODE_QUASI) && latch_in && (!latch_prev_reg || boost_cnt_reg > 2'h1);

   // ----------------------------------------
   // Driver and pull-up control
   // ----------------------------------------
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pad_out              <= 1'b0;
         pad_oe_out           <= 1'b0;
         strong_pullup_out    <= 1'b0;
         weak_pullup_out      <= 1'b0;
         very_weak_pullup_out <= 1'b0;
      end else if (ce_in) begin
         pad_out              <= 1'b0;
         pad_oe_out           <= 1'b0;
         strong_pullup_out    <= 1'b0;
         weak_pullup_out      <= 1'b0;
         very_weak_pullup_out <= 1'b0;
         unique case (mode_in)
            MODE_QUASI: begin
               pad_oe_out           <= !latch_in;
               strong_pullup_out    <= boost;
               very_weak_pullup_out <= latch_in;
               weak_pullup_out      <= latch_in && read_out;
            end
            MODE_PUSH_PULL: begin
               pad_out    <= latch_in;
               pad_oe_out <= 1'b1;
            end
            MODE_INPUT: begin
               pad_oe_out <= 1'b0;
            end
            MODE_OPEN: begin
               pad_oe_out <= !latch_in;
            end
         endcase
      end
   end

endmodule

// ==== io_port_chk.sv ====
// Checker of the I/O port block, bound to its top module.
`timescale 1ns/1ps
module io_port_chk (
   input wire logic        mclk_in,
   input wire logic        resetn_in,
   input wire logic        ce_in,
   input wire logic [7:0]  boot_option_byte_one_in,
   input wire logic        crystal_source_in,
   input wire logic        timer_a_overflow_in,
   input wire logic [23:0] pin_out,
   input wire logic [23:0] pin_oe_out,
   input wire logic [23:0] strong_pullup_out,
   input wire logic [23:0] very_weak_pullup_out,
   input wire logic [23:0] schmitt_enable_out,
   input wire logic        reset_pin_request_out,
   input wire logic [7:0]  port_two_mode_one_out
);
   logic [2:0] since_reg;
   logic [2:0] run_reg;
   wire  [7:0] p2m = port_two_mode_one_out;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   // Counts enabled cycles after reset and cycles of an uninterrupted clock output.
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         since_reg <= 3'h0;
         run_reg   <= 3'h0;
      end else begin
         if (ce_in && since_reg != 3'h7)
            since_reg <= since_reg + 3'h1;
         if (!(p2m[5] && ce_in && !crystal_source_in))
            run_reg <= 3'h0;
         else if (run_reg != 3'h7)
            run_reg <= run_reg + 3'h1;
      end
   end
   no_drive_a: assert property (
      !pin_oe_out[13]) else $error("dedicated pin driven");
   schmitt_sel_a: assert property (
      $rose(p2m[0]) |-> ##[0:2] schmitt_enable_out[0]) else $error("schmitt select ignored");
   clk_quarter_a: assert property (
      run_reg == 3'h7 |-> pin_oe_out[16] && pin_out[16] != $past(pin_out[16], 2)) else $error("clock out rate");
   timer_tog_a: assert property (
      p2m[3] && $past(p2m[3]) && timer_a_overflow_in && ce_in ##1 ce_in && p2m[3] |=>
      pin_out[6] != $past(pin_out[6])) else $error("timer toggle missing");
   strong_two_a: assert property (
      $rose(strong_pullup_out[0]) |-> strong_pullup_out[0] [*2] ##1 !strong_pullup_out[0])
      else $error("strong pull-up length");
   no_strong_low_a: assert property (
      (strong_pullup_out & pin_oe_out & ~pin_out) == 24'h0) else $error("strong pull-up while low");
   vweak_high_a: assert property (
      (very_weak_pullup_out & pin_oe_out & ~pin_out) == 24'h0) else $error("very weak pull-up while low");
   reset_level_a: assert property (
      since_reg == 3'h3 |-> (boot_option_byte_one_in[5] ? (!pin_oe_out[0] && very_weak_pullup_out[0])
      : (pin_oe_out[0] && !pin_out[0]))) else $error("pin level after reset");
   reset_quiet_a: assert property (
      since_reg <= 3'h4 |-> !reset_pin_request_out) else $error("reset request before input settled");
   cover property (run_reg == 3'h7);
   cover property ($changed(pin_out[6]) && p2m[3]);
   cover property ($rose(strong_pullup_out[0]));
endmodule
bind io_port_pin_config io_port_chk chk (.mclk_in, .resetn_in, .ce_in, .boot_option_byte_one_in,
   .crystal_source_in, .timer_a_overflow_in, .pin_out, .pin_oe_out, .strong_pullup_out,
   .very_weak_pullup_out, .schmitt_enable_out, .reset_pin_request_out, .port_two_mode_one_out);

// ==== board_model.sv ====
// Board circuitry model: resolves pad levels from the block's drive and an external driver.
`timescale 1ns/1ps
module board_model (
   input  wire logic        mclk_in,
   input  wire logic [23:0] drive_in,
   input  wire logic [23:0] oe_in,
   input  wire logic [23:0] pull_in,
   input  wire logic [23:0] ext_en_in,
   input  wire logic [23:0] ext_val_in,
   output logic      [23:0] level_out
);
   logic float_reg;
   initial float_reg = 1'b0;
   // A released pad with no pull-up shows a changing level, never its last value.
   always @(posedge mclk_in) float_reg <= ~float_reg;
   assign level_out = (oe_in & drive_in) | (~oe_in & ext_en_in & ext_val_in)
                    | (~oe_in & ~ext_en_in & (pull_in | {24{float_reg}}));
endmodule

// ==== testbench.sv ====
// Self-checking bench of the I/O port block.
`timescale 1ns/1ps
module testbench;
   logic        mclk_in, resetn_in, ce_in, xtal, lwr, mwr, pwr, ova, ovb, rst_req, o16;
   logic [1:0]  o67;
   logic [7:0]  boot, pdat, p2o, pv;
   logic [23:0] ldat, ma, mb, lvl, ext_en, ext_val, po, poe, sp, wp, vwp, sch, rd, la, lb, ll, pl, qs, pp;
   logic [31:0] seed;
   logic [47:0] e;
   int          miscompares, num_checks, i;
   io_port_pin_config dut (.mclk_in, .resetn_in, .ce_in, .boot_option_byte_one_in(boot),
      .crystal_source_in(xtal), .latch_wr_in(lwr), .latch_wdata_in(ldat), .mode_wr_in(mwr),
      .pin_mode_bit_a_in(ma), .pin_mode_bit_b_in(mb), .port_two_mode_one_wr_in(pwr),
      .port_two_mode_one_wdata_in(pdat), .timer_a_overflow_in(ova), .timer_b_overflow_in(ovb),
      .pin_in(lvl), .pin_out(po), .pin_oe_out(poe), .strong_pullup_out(sp), .weak_pullup_out(wp),
      .very_weak_pullup_out(vwp), .schmitt_enable_out(sch), .pin_read_out(rd),
      .port_two_mode_one_out(p2o), .reset_pin_request_out(rst_req));
   board_model bm (.mclk_in, .drive_in(po), .oe_in(poe), .pull_in(sp | wp | vwp),
      .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));
   initial begin
      mclk_in = 1'b0;
      forever #20 mclk_in = ~mclk_in;
   end
   function automatic logic [23:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[23:0];
   endfunction
   // Push-pull drives the latch; quasi and open drain drive only a low; input never drives.
   function automatic logic [47:0] exp_drv(logic [23:0] a, logic [23:0] b, logic [23:0] l);
      logic [23:0] oe;
      oe = ((b & ~a) | (~(a ^ b) & ~l)) & 24'hFFDFFF;
      return {oe, b & ~a & l & 24'hFFDFFF};
   endfunction
   task automatic tick(int n);
      repeat (n) @(posedge mclk_in);
   endtask
   task automatic chk(logic [23:0] got, logic [23:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      if (miscompares == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic do_reset(logic [7:0] b);
      @(posedge mclk_in);
      resetn_in <= 1'b0;
      boot <= b;
      tick(5);
      resetn_in <= 1'b1;
      tick(8);
   endtask
   task automatic wr_pins(logic [23:0] a, logic [23:0] b, logic [23:0] l);
      @(posedge mclk_in);
      {mwr, lwr, ma, mb, ldat} <= {2'b11, a, b, l};
      @(posedge mclk_in);
      {mwr, lwr} <= 2'b00;
      tick(3);
   endtask
   task automatic wr_p2(logic [7:0] v);
      @(posedge mclk_in);
      {pwr, pdat} <= {1'b1, v};
      @(posedge mclk_in);
      pwr <= 1'b0;
      tick(3);
   endtask
   initial begin
      {resetn_in, xtal, lwr, mwr, pwr, ova, ovb, pdat, ldat, ma, mb, ext_en, ext_val} = '0;
      {ce_in, boot, seed, miscompares, num_checks} = {1'b1, 8'h20, 32'h12, 64'h0};
      do_reset(8'h20);
      chk(poe, 24'h0);
      chk(vwp & 24'hFFDFFF, 24'hFFDFFF);
      ext_en[13] <= 1'b1;
      ext_val[13] <= 1'b1;
      tick(8);
      chk({23'h0, rst_req}, 24'h0);
      ext_val[13] <= 1'b0;
      for (i = 0; i < 20 && rst_req !== 1'b1; i++)
         tick(1);
      chk({23'h0, rst_req}, 24'h1);
      do_reset(8'h40);
      chk(poe & ~po, 24'hFFDFFF);
      chk({23'h0, rst_req}, 24'h0);
      ext_val[13] <= 1'b1;
      tick(8);
      chk(rd & 24'h002000, 24'h002000);
      pl = 24'h000000;
      for (i = 0; i < 40; i++) begin
         {la, lb, ll} = {rnd(), rnd(), rnd()};
         if (i < 2)
            {la, lb, ll} = {48'h0, {24{i[0]}}};
         wr_pins(la, lb, ll);
         e = exp_drv(la, lb, ll);
         qs = ~la & ~lb & 24'hFFDFFF;
         pp = ~la & lb & 24'hFFDFFF;
         chk(poe, e[47:24]);
         chk(po & poe, e[23:0]);
         chk(vwp, qs & ll);
         chk(sp, qs & ll & ~pl);
         tick(4);
         chk(wp, qs & ll);
         chk(sp, 24'h000000);
         chk(rd & (qs | pp | (la & lb & ~ll & 24'hFFDFFF)), (qs | pp) & ll);
         pl = ll;
      end
      for (i = 0; i < 8; i++) begin
         pv = {2'b00, i[2:0], i[2:0]};
         wr_p2(pv);
         chk({16'h0, p2o}, {16'h0, pv});
         chk(sch, {{8{pv[2]}}, {8{pv[1]}}, {8{pv[0]}}} | 24'h002000);
         o67 = po[7:6];
         @(posedge mclk_in);
         {ova, ovb} <= 2'b11;
         @(posedge mclk_in);
         {ova, ovb} <= 2'b00;
         tick(3);
         chk({22'h0, po[7:6] ^ o67}, {22'h0, pv[4:3]});
      end
      o16 = po[16];
      tick(2);
      chk({23'h0, po[16]}, {23'h0, ~o16});
      chk(poe & 24'h010000, 24'h010000);
      xtal <= 1'b1;
      tick(3);
      o16 = po[16];
      tick(2);
      chk({23'h0, po[16]}, {23'h0, o16});
      xtal <= 1'b0;
      ce_in <= 1'b0;
      wr_p2(8'h00);
      ce_in <= 1'b1;
      tick(2);
      chk({16'h0, p2o}, 24'h00003F);
      end_sim();
   end
   initial begin
      repeat (20000) @(posedge mclk_in);
      miscompares++;
      end_sim();
   end
endmodule
